/* File: rtl/l2cp_defines.vh */
// constants of the second-level cache pin port
// Operation
// - 20-bit cache index output, bits 23:4
// - 128-bit data bus with 16 ECC bits
// - data array read enable low during reads
// - data array write enable low on writes
// - tag array read enable low during reads
// - tag array write enable low on writes
// - dirty bit high when line was modified
// - shared bit written 1 if others hold line
// - tag valid bit set means line valid
// - free-running differential clocks, fixed global multiple
// - clock rise lags index 0-2 cycles
// - tag outputs launched with cache clocks
// - tag clocks copy the data clocks
// - eight rx clocks capture read data, resync
// - tag read latched by tag rx clock
// - wake input registered by framing clock
`ifndef L2CP_DEFINES_VH
`define L2CP_DEFINES_VH
// ********************************
// widths
// ********************************
`define L2CP_IDX_W    20
`define L2CP_DATA_W   128
`define L2CP_ECC_W    16
`define L2CP_TAG_W    23
`define L2CP_LANES    8
`define L2CP_LANE_W   16
`define L2CP_LECC_W   2
// ********************************
// cache clock and transfers
// ********************************
`define L2CP_CLK_PER  2'h3
`define L2CP_CLK_HALF 2'h2
`define L2CP_BURST    3'h4
`define L2CP_FIFO_D   4
`define L2CP_FIFO_AW  2
// ********************************
// read response word fields
// ********************************
`define L2CP_RSP_W    171
`define L2CP_F_ECC    128
`define L2CP_F_TAG    144
`define L2CP_F_VALID  167
`define L2CP_F_DIRTY  168
`define L2CP_F_SHARED 169
`define L2CP_F_PERR   170
// ********************************
// sequencer states
// ********************************
`define L2CP_ST_IDLE  2'h0
`define L2CP_ST_WR    2'h1
`define L2CP_ST_RD    2'h2
`endif

/* File: rtl/l2cp_sync.v */
// two-stage synchroniser for a bundle of pin inputs
`timescale 1ns/10ps
module l2cp_sync #(
    parameter W = 1
) (
    sys_clk,                       // core clock
    rst,                           // async reset, high
    din,                           // raw pin levels
    dout                           // levels after two flops
);
    input  wire         sys_clk;   // core clock
    input  wire         rst;       // async reset, high
    input  wire [W-1:0] din;       // raw pin levels
    output reg  [W-1:0] dout;      // second stage
    reg         [W-1:0] meta_q;    // first stage, read by dout only

    // two flops, only the second looks at the first
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            meta_q <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule // l2cp_sync

/* File: rtl/l2cp_fifo.v */
// small valid/ready fifo for read responses
`timescale 1ns/10ps
module l2cp_fifo #(
    parameter W  = 8,
    parameter D  = 4,
    parameter AW = 2
) (
    sys_clk,                        // core clock
    rst,                            // async reset, high
    in_valid,                       // write side valid
    in_ready,                       // not full
    in_data,                        // write word
    out_valid,                      // not empty
    out_ready,                      // read side takes word
    out_data                        // head word
);
    input  wire          sys_clk;   // core clock
    input  wire          rst;       // async reset, high
    input  wire          in_valid;  // write side valid
    output wire          in_ready;  // not full
    input  wire [W-1:0]  in_data;   // write word
    output wire          out_valid; // not empty
    input  wire          out_ready; // read side takes word
    output wire [W-1:0]  out_data;  // head word
    reg    [W-1:0]       mem [0:D-1]; // storage
    reg    [AW-1:0]      wp_q;      // write pointer
    reg    [AW-1:0]      rp_q;      // read pointer
    reg    [AW:0]        cnt_q;     // fill level
    wire                 push;      // word enters
    wire                 pop;       // word leaves

    assign in_ready  = (cnt_q != D[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem[rp_q];

    // storage, no reset needed
    always @(posedge sys_clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    // pointers and fill level
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wp_q  <= {AW{1'b0}};
            rp_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            if (push & ~pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop & ~push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // l2cp_fifo

/* File: rtl/l2cp_port.v */
// second-level cache pin port: sequencer, clocks, capture
`timescale 1ns/10ps
`include "l2cp_defines.vh"
module l2cp_port (
    sys_clk,          // core global clock
    rst,              // async reset, high
    clk_lag,          // index-to-clock lag, 0..2
    req_valid,        // access request
    req_ready,        // request taken when both high
    req_write,        // 1 write, 0 read
    req_burst,        // read of four beats
    req_index,        // line index
    req_data,         // write data
    req_ecc,          // write check bits
    req_tag,          // write tag
    req_line_valid,   // write valid state
    req_dirty,        // line was modified
    req_shared,       // other agent holds line
    rd_valid,         // read beat available
    rd_ready,         // read beat taken
    rd_data,          // read data
    rd_ecc,           // read check bits
    rd_tag,           // read tag
    rd_line_valid,    // read valid state
    rd_dirty,         // read dirty state
    rd_shared,        // read shared state
    rd_parity_err,    // tag parity mismatch
    cache_index_out,  // index pins
    cache_data_out,   // data pins, driven
    cache_data_in,    // data pins, received
    cache_ecc_out,    // check pins, driven
    cache_ecc_in,     // check pins, received
    cache_bus_oe_n,   // data/check pin enable, low drives
    cache_data_rx_clk,// returned data clocks
    data_array_oe_n,  // data array read enable
    data_array_we_n,  // data array write enable
    burst_enable_n,   // burst start
    cache_clk_out_p,  // cache clocks, true
    cache_clk_out_n,  // cache clocks, complement
    tag_clk_out_p,    // tag clocks, true
    tag_clk_out_n,    // tag clocks, complement
    tag_bus_out,      // tag pins, driven
    tag_bus_in,       // tag pins, received
    tag_state_out,    // {parity,shared,dirty,valid} driven
    tag_state_in,     // {parity,shared,dirty,valid} received
    tag_bus_oe_n,     // tag pin enable, low drives
    tag_rx_clk,       // returned tag clock
    tag_array_oe_n,   // tag array read enable
    tag_array_we_n,   // tag array write enable
    framing_clock,    // system framing clock
    wake_request,     // system wake input
    wake_flag         // wake level as registered
);
    input  wire                    sys_clk;           // core clock
    input  wire                    rst;               // reset
    input  wire [1:0]              clk_lag;           // lag select
    input  wire                    req_valid;         // request
    output reg                     req_ready;         // accept
    input  wire                    req_write;         // write
    input  wire                    req_burst;         // burst read
    input  wire [`L2CP_IDX_W-1:0]  req_index;         // index
    input  wire [`L2CP_DATA_W-1:0] req_data;          // data
    input  wire [`L2CP_ECC_W-1:0]  req_ecc;           // ecc
    input  wire [`L2CP_TAG_W-1:0]  req_tag;           // tag
    input  wire                    req_line_valid;    // valid
    input  wire                    req_dirty;         // dirty
    input  wire                    req_shared;        // shared
    output wire                    rd_valid;          // beat ready
    input  wire                    rd_ready;          // beat taken
    output wire [`L2CP_DATA_W-1:0] rd_data;           // data
    output wire [`L2CP_ECC_W-1:0]  rd_ecc;            // ecc
    output wire [`L2CP_TAG_W-1:0]  rd_tag;            // tag
    output wire                    rd_line_valid;     // valid
    output wire                    rd_dirty;          // dirty
    output wire                    rd_shared;         // shared
    output wire                    rd_parity_err;     // parity
    output reg  [`L2CP_IDX_W-1:0]  cache_index_out;   // index
    output reg  [`L2CP_DATA_W-1:0] cache_data_out;    // data out
    input  wire [`L2CP_DATA_W-1:0] cache_data_in;     // data in
    output reg  [`L2CP_ECC_W-1:0]  cache_ecc_out;     // ecc out
    input  wire [`L2CP_ECC_W-1:0]  cache_ecc_in;      // ecc in
    output reg                     cache_bus_oe_n;    // pin enable
    input  wire [`L2CP_LANES-1:0]  cache_data_rx_clk; // rx clocks
    output reg                     data_array_oe_n;   // array oe
    output reg                     data_array_we_n;   // array we
    output reg                     burst_enable_n;    // burst
    output wire [3:0]              cache_clk_out_p;   // clk true
    output wire [3:0]              cache_clk_out_n;   // clk comp
    output wire [1:0]              tag_clk_out_p;     // tag clk
    output wire [1:0]              tag_clk_out_n;     // tag clk n
    output reg  [`L2CP_TAG_W-1:0]  tag_bus_out;       // tag out
    input  wire [`L2CP_TAG_W-1:0]  tag_bus_in;        // tag in
    output reg  [3:0]              tag_state_out;     // state out
    input  wire [3:0]              tag_state_in;      // state in
    output reg                     tag_bus_oe_n;      // pin enable
    input  wire                    tag_rx_clk;        // tag rx clk
    output reg                     tag_array_oe_n;    // array oe
    output reg                     tag_array_we_n;    // array we
    input  wire                    framing_clock;     // frame clk
    input  wire                    wake_request;      // wake
    output reg                     wake_flag;         // wake reg

    // ********************************
    // pin input synchronisers
    // ********************************
    localparam SW = `L2CP_DATA_W + `L2CP_ECC_W + `L2CP_TAG_W + 4 + 11;
    wire [SW-1:0] s_d;                   // synced bundle
    wire [`L2CP_DATA_W-1:0] s_data;      // synced data
    wire [`L2CP_ECC_W-1:0]  s_ecc;       // synced ecc
    wire [`L2CP_TAG_W-1:0]  s_tag;       // synced tag
    wire [3:0]              s_state;     // synced state bits
    wire [`L2CP_LANES-1:0]  s_rxc;       // synced rx clocks
    wire                    s_trxc;      // synced tag rx clock
    wire                    s_frm;       // synced framing clock
    wire                    s_wake;      // synced wake input
    reg  [10:0]             clk3_q;      // third stage for edges
    wire [`L2CP_LANES-1:0]  lane_edge;   // rx clock rises
    wire                    tag_edge;    // tag rx clock rises
    wire                    frm_edge;    // framing clock rises

    l2cp_sync #(.W(SW)) u_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .din     ({cache_data_in, cache_ecc_in, tag_bus_in, tag_state_in,
                   cache_data_rx_clk, tag_rx_clk, framing_clock,
                   wake_request}),
        .dout    (s_d)
    );
    assign {s_data, s_ecc, s_tag, s_state, s_rxc, s_trxc, s_frm,
            s_wake} = s_d;

    // edge detectors compare the second stage with the third
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clk3_q <= 11'h000;
        end else begin
            clk3_q <= {s_rxc, s_trxc, s_frm, s_wake};
        end
    end
    assign lane_edge = s_rxc & ~clk3_q[10:3];
    assign tag_edge  = s_trxc & ~clk3_q[2];
    assign frm_edge  = s_frm & ~clk3_q[1];

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wake_flag <= 1'b0;
        end else if (frm_edge) begin
            wake_flag <= s_wake;
        end
    end

    // ********************************
    // read capture lanes
    // ********************************
    reg  [`L2CP_LANES-1:0]  got_q;       // lane holds a beat
    reg                     tgot_q;      // tag holds a beat
    reg  [`L2CP_TAG_W-1:0]  ctag_q;      // captured tag
    reg  [3:0]              cst_q;       // captured state bits
    wire [`L2CP_DATA_W-1:0] cdata;       // captured data
    wire [`L2CP_ECC_W-1:0]  cecc;        // captured ecc
    wire                    cap_clr;     // beat consumed
    genvar gi;

    generate
        for (gi = 0; gi < `L2CP_LANES; gi = gi + 1) begin : g_lane
            reg [`L2CP_LANE_W-1:0] ld_q;  // lane data
            reg [`L2CP_LECC_W-1:0] le_q;  // lane check bits
            always @(posedge sys_clk or posedge rst) begin
                if (rst) begin
                    ld_q      <= {`L2CP_LANE_W{1'b0}};
                    le_q      <= {`L2CP_LECC_W{1'b0}};
                    got_q[gi] <= 1'b0;
                end else begin
                    if (lane_edge[gi]) begin
                        ld_q <= s_data[gi*16 +: 16];
                        le_q <= s_ecc[gi*2 +: 2];
                    end
                    // a new edge wins over the clear
                    got_q[gi] <= lane_edge[gi] | (got_q[gi] & ~cap_clr);
                end
            end
            assign cdata[gi*16 +: 16] = ld_q;
            assign cecc[gi*2 +: 2]    = le_q;
        end
    endgenerate

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ctag_q <= {`L2CP_TAG_W{1'b0}};
            cst_q  <= 4'h0;
            tgot_q <= 1'b0;
        end else begin
            if (tag_edge) begin
                ctag_q <= s_tag;
                cst_q  <= s_state;
            end
            tgot_q <= tag_edge | (tgot_q & ~cap_clr);
        end
    end

    // ********************************
    // cache clock generator
    // ********************************
    reg  [1:0] ph_q;                     // phase in clock period
    reg        cclk_q;                   // true clock
    reg        cclk_n_q;                 // complement clock
    wire [1:0] ph_d;                     // next phase
    wire [1:0] launch;                   // phase where index moves

    assign ph_d   = (ph_q == `L2CP_CLK_PER) ? 2'h0 : ph_q + 2'h1;
    assign launch = (clk_lag == 2'h0) ? 2'h0 :
                    (clk_lag == 2'h1) ? 2'h3 : 2'h2;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            ph_q     <= 2'h3;
            cclk_q   <= 1'b0;
            cclk_n_q <= 1'b1;
        end else begin
            ph_q     <= ph_d;
            cclk_q   <= (ph_d < `L2CP_CLK_HALF);
            cclk_n_q <= ~(ph_d < `L2CP_CLK_HALF);
        end
    end
    assign cache_clk_out_p = {4{cclk_q}};
    assign cache_clk_out_n = {4{cclk_n_q}};
    assign tag_clk_out_p   = {2{cclk_q}};
    assign tag_clk_out_n   = {2{cclk_n_q}};

    // ********************************
    // access sequencer
    // ********************************
    reg  [1:0] st_q;                     // state
    reg  [1:0] st_d;                     // next state
    reg  [1:0] cyc_q;                    // cycle inside access
    reg  [2:0] beats_q;                  // read beats left
    wire       take;                     // request accepted
    wire       beat_in;                  // full beat captured
    wire       fifo_ready;               // response room
    wire       push;                     // beat into fifo
    wire [3:0] rd_st;                    // read state bits

    assign take    = req_valid & req_ready;
    assign beat_in = (&got_q) & tgot_q;
    assign push    = (st_q == `L2CP_ST_RD) & beat_in & fifo_ready;
    assign cap_clr = push | take;

    // next state
    always @* begin
        st_d = st_q;
        case (st_q)
            `L2CP_ST_IDLE: begin
                if (take) begin
                    st_d = req_write ? `L2CP_ST_WR : `L2CP_ST_RD;
                end
            end
            `L2CP_ST_WR: begin
                if (cyc_q == `L2CP_CLK_PER) begin
                    st_d = `L2CP_ST_IDLE;
                end
            end
            `L2CP_ST_RD: begin
                if (push && beats_q == 3'h1) begin
                    st_d = `L2CP_ST_IDLE;
                end
            end
            default: begin
                st_d = `L2CP_ST_IDLE;
            end
        endcase
    end

    // sequencer and pin registers
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_q            <= `L2CP_ST_IDLE;
            cyc_q           <= 2'h0;
            beats_q         <= 3'h0;
            req_ready       <= 1'b0;
            cache_index_out <= {`L2CP_IDX_W{1'b0}};
            cache_data_out  <= {`L2CP_DATA_W{1'b0}};
            cache_ecc_out   <= {`L2CP_ECC_W{1'b0}};
            cache_bus_oe_n  <= 1'b1;
            data_array_oe_n <= 1'b1;
            data_array_we_n <= 1'b1;
            burst_enable_n  <= 1'b1;
            tag_bus_out     <= {`L2CP_TAG_W{1'b0}};
            tag_state_out   <= 4'h0;
            tag_bus_oe_n    <= 1'b1;
            tag_array_oe_n  <= 1'b1;
            tag_array_we_n  <= 1'b1;
        end else begin
            st_q      <= st_d;
            // open one cycle before each launch phase when the next state is idle
            req_ready <= (st_d == `L2CP_ST_IDLE) &&
                         ((ph_d + 2'h1) == launch);
            cyc_q     <= (st_q == `L2CP_ST_IDLE) ? 2'h0 : cyc_q + 2'h1;
            if (take) begin
                cache_index_out <= req_index;
                burst_enable_n  <= ~(req_burst & ~req_write);
                beats_q <= (req_burst & ~req_write) ? `L2CP_BURST : 3'h1;
                if (req_write) begin
                    cache_data_out <= req_data;
                    cache_ecc_out  <= req_ecc;
                    cache_bus_oe_n <= 1'b0;
                    data_array_we_n <= 1'b0;
                    tag_bus_out    <= req_tag;
                    tag_state_out  <= {^{req_tag, req_shared, req_dirty,
                                         req_line_valid},
                                       req_shared, req_dirty,
                                       req_line_valid};
                    tag_bus_oe_n   <= 1'b0;
                    tag_array_we_n <= 1'b0;
                end else begin
                    data_array_oe_n <= 1'b0;
                    tag_array_oe_n  <= 1'b0;
                end
            end else begin
                if (st_q == `L2CP_ST_RD && cyc_q == `L2CP_CLK_PER) begin
                    burst_enable_n <= 1'b1;
                end
                if (push) begin
                    beats_q <= beats_q - 3'h1;
                end
                if (st_d == `L2CP_ST_IDLE) begin
                    // release everything after the access
                    burst_enable_n  <= 1'b1;
                    cache_bus_oe_n  <= 1'b1;
                    tag_bus_oe_n    <= 1'b1;
                    data_array_oe_n <= 1'b1;
                    data_array_we_n <= 1'b1;
                    tag_array_oe_n  <= 1'b1;
                    tag_array_we_n  <= 1'b1;
                end
            end
        end
    end

    // ********************************
    // read response buffer
    // ********************************
    wire [`L2CP_RSP_W-1:0] rsp_in;       // beat to buffer
    wire [`L2CP_RSP_W-1:0] rsp_out;      // head beat

    assign rd_st  = {cst_q[3] ^ (^{ctag_q, cst_q[2:0]}), cst_q[2:0]};
    assign rsp_in = {rd_st, ctag_q, cecc, cdata};

    l2cp_fifo #(
        .W  (`L2CP_RSP_W),
        .D  (`L2CP_FIFO_D),
        .AW (`L2CP_FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (push),
        .in_ready  (fifo_ready),
        .in_data   (rsp_in),
        .out_valid (rd_valid),
        .out_ready (rd_ready),
        .out_data  (rsp_out)
    );
    assign rd_data       = rsp_out[`L2CP_F_ECC-1:0];
    assign rd_ecc        = rsp_out[`L2CP_F_TAG-1:`L2CP_F_ECC];
    assign rd_tag        = rsp_out[`L2CP_F_VALID-1:`L2CP_F_TAG];
    assign rd_line_valid = rsp_out[`L2CP_F_VALID];
    assign rd_dirty      = rsp_out[`L2CP_F_DIRTY];
    assign rd_shared     = rsp_out[`L2CP_F_SHARED];
    assign rd_parity_err = rsp_out[`L2CP_F_PERR];
endmodule // l2cp_port

/* File: sim/l2cp_port_asserts.sv */
// assertion checker for the cache pin port
`timescale 1ns/10ps
module l2cp_port_asserts (
    input wire sys_clk, rst, req_valid, req_ready, req_write, req_burst,
    input wire data_array_oe_n, data_array_we_n, tag_array_oe_n,
    input wire tag_array_we_n, burst_enable_n, cache_bus_oe_n, tag_bus_oe_n,
    input wire [3:0] cache_clk_out_p, cache_clk_out_n, tag_state_out,
    input wire [1:0] tag_clk_out_p, tag_clk_out_n,
    input wire [22:0] tag_bus_out);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_clk_diff: assert property (
        cache_clk_out_n == ~cache_clk_out_p)
        else $error("cache clock pair not complementary");
    a_clk_period: assert property (
        $rose(cache_clk_out_p[0]) |-> cache_clk_out_p[0] [*2] ##1
        !cache_clk_out_p[0] [*2] ##1 cache_clk_out_p[0])
        else $error("cache clock period wrong");
    a_tag_echo: assert property (
        tag_clk_out_p == cache_clk_out_p[1:0] &&
        tag_clk_out_n == cache_clk_out_n[1:0])
        else $error("tag clock differs");
    a_wr_take: assert property (
        req_valid && req_ready && req_write |=> !data_array_we_n &&
        !tag_array_we_n && !cache_bus_oe_n && !tag_bus_oe_n)
        else $error("write enables missing");
    a_wr_len: assert property (
        $fell(data_array_we_n) |-> !data_array_we_n [*4] ##1 data_array_we_n)
        else $error("write enable width wrong");
    a_rd_take: assert property (
        req_valid && req_ready && !req_write |=> !data_array_oe_n &&
        !tag_array_oe_n && cache_bus_oe_n && tag_bus_oe_n)
        else $error("read enables missing");
    a_burst_len: assert property (
        req_valid && req_ready && !req_write && req_burst |=>
        !burst_enable_n [*4] ##1 burst_enable_n)
        else $error("burst enable width wrong");
    a_tag_par: assert property (
        !tag_array_we_n |-> !(^{tag_bus_out, tag_state_out}))
        else $error("tag parity odd");
endmodule // l2cp_port_asserts
bind l2cp_port l2cp_port_asserts u_l2cp_port_asserts (.*);

/* File: sim/l2cp_sram_model.sv */
// cache sram arrays answering reads with forwarded clocks
`timescale 1ns/10ps
module l2cp_sram_model (
    input wire sys_clk, data_array_we_n, data_array_oe_n, burst_enable_n,
    input wire [127:0] cache_data_out,
    input wire [15:0] cache_ecc_out,
    input wire [22:0] tag_bus_out,
    input wire [3:0] tag_state_out,
    output reg [127:0] cache_data_in,
    output reg [15:0] cache_ecc_in,
    output reg [22:0] tag_bus_in,
    output reg [3:0] tag_state_in,
    output reg [7:0] cache_data_rx_clk,
    output reg tag_rx_clk);
    reg [170:0] line_q; // one stored line
    integer pend = 0; // beats still owed
    initial {cache_data_rx_clk, tag_rx_clk, line_q} = 0;
    initial {tag_state_in, tag_bus_in, cache_ecc_in, cache_data_in} = 0;
    // store the line on write enable
    always @(posedge sys_clk) if (!data_array_we_n)
        line_q <= {tag_state_out, tag_bus_out, cache_ecc_out, cache_data_out};
    // a read start owes one beat, a burst start four
    always @(negedge data_array_oe_n)
        #1 pend = pend + (burst_enable_n ? 1 : 4);
    // eight data clocks plus tag clock, 160 ns per beat
    always begin
        wait (pend > 0);
        pend = pend - 1;
        #16 {tag_state_in, tag_bus_in, cache_ecc_in, cache_data_in} = line_q;
        #20 {cache_data_rx_clk, tag_rx_clk} = 9'h1ff;
        #80 {cache_data_rx_clk, tag_rx_clk} = 9'h000;
        #44 {tag_state_in, tag_bus_in, cache_ecc_in, cache_data_in} = ~line_q;
    end
endmodule // l2cp_sram_model

/* File: sim/tb.sv */
// self-checking bench for the cache pin port
`timescale 1ns/10ps
module tb;
    reg sys_clk = 0, rst = 1, req_valid = 0, req_write = 0, req_burst = 0;
    reg rd_ready = 0, framing_clock = 0, wake_request = 0, req_line_valid = 0;
    reg req_dirty = 0, req_shared = 0;
    reg [1:0] clk_lag = 0;
    reg [19:0] req_index = 0;
    reg [127:0] req_data = 0;
    reg [15:0] req_ecc = 0;
    reg [22:0] req_tag = 0;
    integer bad_count = 0, samples_checked = 0, cyc = 0, i, k;
    wire [127:0] rd_data, cache_data_out, cache_data_in;
    wire [15:0] rd_ecc, cache_ecc_out, cache_ecc_in;
    wire [22:0] rd_tag, tag_bus_out, tag_bus_in;
    wire [19:0] cache_index_out;
    wire [7:0] cache_data_rx_clk;
    wire [3:0] cache_clk_out_p, cache_clk_out_n, tag_state_out, tag_state_in;
    wire [1:0] tag_clk_out_p, tag_clk_out_n;
    wire req_ready, rd_valid, rd_line_valid, rd_dirty, rd_shared, wake_flag;
    wire rd_parity_err, cache_bus_oe_n, data_array_oe_n, data_array_we_n;
    wire burst_enable_n, tag_bus_oe_n, tag_rx_clk, tag_array_oe_n;
    wire tag_array_we_n;
    l2cp_port u_l2cp_port (.*);
    l2cp_sram_model u_l2cp_sram_model (.*);
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc = cyc + 1;
        if (cyc == 5000) begin bad_count = bad_count + 1; end_sim; end
    end
    task chk(input string nm, input [170:0] e, input [170:0] g);
        samples_checked = samples_checked + 1;
        if (g !== e) begin
            bad_count = bad_count + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, e, g);
        end
    endtask
    task take(input w, input b);
        @(negedge sys_clk);
        {req_write, req_burst, req_valid} = {w, b, 1'b1};
        for (k = 0; !req_ready && k < 200; k = k + 1) @(negedge sys_clk);
        chk("ready", 1, req_ready);
        @(negedge sys_clk);
        req_valid = 0;
    endtask
    task pop(input pe);
        for (k = 0; !rd_valid && k < 200; k = k + 1) @(negedge sys_clk);
        chk("rdvalid", 1, rd_valid);
        chk("rdword", {pe, req_shared, req_dirty, req_line_valid,
            req_tag ^ pe, req_ecc, req_data}, {rd_parity_err, rd_shared,
            rd_dirty, rd_line_valid, rd_tag, rd_ecc, rd_data});
        rd_ready = 1;
        @(negedge sys_clk);
        rd_ready = 0;
    endtask
    task t_write(input [1:0] lag, input [2:0] st);
        {clk_lag, req_index, req_tag} = {lag, 20'ha5c3f ^ lag, 20'h5a5a5, st};
        {req_shared, req_dirty, req_line_valid} = st;
        {req_data, req_ecc} = {{4{32'hc3a50f1e}} ^ lag, 16'h9e37 ^ st};
        take(1, 0);
        chk("index", req_index, cache_index_out);
        for (k = 0; !cache_clk_out_p[0] && k < 4; k = k + 1)
            @(negedge sys_clk);
        chk("lag", lag, k);
        chk("wrpins", {^{req_tag, st}, st, req_tag, req_ecc,
            req_data}, {tag_state_out, tag_bus_out, cache_ecc_out,
            cache_data_out});
    endtask
    task t_wake(input v);
        wake_request = v;
        #80 chk("wakehold", !v, wake_flag);
        framing_clock = 1;
        #80 framing_clock = 0;
        chk("wake", v, wake_flag);
    endtask
    task end_sim;
        $display("compared %0d mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge sys_clk);
        rst = 0;
        for (i = 0; i < 3; i = i + 1) begin
            t_write(i, i * 3 + 1);
            take(0, 0);
            pop(0);
        end
        take(0, 1);
        take(0, 0);
        repeat (60) @(negedge sys_clk);
        chk("stall", 0, data_array_oe_n);
        repeat (5) pop(0);
        // flip one stored tag bit so the read sees a parity error
        u_l2cp_sram_model.line_q[144] = ~u_l2cp_sram_model.line_q[144];
        take(0, 0);
        pop(1);
        t_wake(1);
        t_wake(0);
        end_sim;
    end
endmodule // tb
